// ---- shared/alu_exec_pkg.sv ----
// constants, fields and opcode set shared by the execution datapath
// Behaviour
// - add-with-carry to accumulator: acc+mem+carry into acc, update ov, z, ac, c
// - add-with-carry to memory: acc+mem+carry into the data byte, same four flags
// - plain adds from memory or immediate into acc or memory, same four flags
// - bitwise and of acc with memory or immediate, only zero flag changes
// - call pushes pc plus one, then loads target address, flags untouched
// - clear byte writes all zeros to memory, no flag changes
// - clear bit forces the selected bit low, other bits and flags kept
// - watchdog clear zeroes counter and clears expiry and sleep-entry flags
// - paired preclears clear watchdog and flags only once both have run
// - invert writes ones complement to memory or acc, only zero flag changes
// - bcd adjust adds six to low nibble if above nine or half carry
// - bcd high nibble gets low carry, plus six and carry set if needed
// - decrement memory in place or into acc, only zero flag changes
// - increment memory in place or into acc, only zero flag changes
// - power-down advances pc, stops execution, keeps memory and registers
// - power-down clears watchdog and prescaler, sets sleep flag, clears expiry
// - direct branch loads pc with target address unconditionally
package alu_exec_pkg;

    localparam int DATA_W      = 8;
    localparam int PC_W        = 12;
    localparam int MEM_DEPTH   = 192;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W        = 3;
    localparam int ADDR_W      = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_INSTR    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ACC      = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PC       = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_MEM_ADDR = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_MEM_DATA = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_WDT      = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STACK    = 8'h1C;

    // instruction word fields
    localparam int INS_OP_LSB   = 0;
    localparam int INS_OP_W     = 5;
    localparam int INS_BIT_LSB  = 5;
    localparam int INS_ADDR_LSB = 8;
    localparam int INS_IMM_LSB  = 16;

    // status register bit positions
    localparam int ST_C     = 0;
    localparam int ST_AC    = 1;
    localparam int ST_Z     = 2;
    localparam int ST_OV    = 3;
    localparam int ST_PDF   = 4;
    localparam int ST_TO    = 5;
    localparam int ST_SLEEP = 6;
    localparam int ST_PRE1  = 7;
    localparam int ST_PRE2  = 8;

    // reset values
    localparam logic [DATA_W-1:0] RST_ACC = 8'h00;
    localparam logic [PC_W-1:0]   RST_PC  = 12'h000;
    localparam logic [DATA_W-1:0] RST_WDT = 8'h00;

    // decimal adjust constants
    localparam logic [3:0] BCD_LIMIT = 4'h9;
    localparam logic [3:0] BCD_STEP  = 4'h6;

    // watchdog prescaler terminal count
    localparam logic [7:0] WDT_PRESCALE_DEF = 8'hFF;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [INS_OP_W-1:0] {
        op_adc, op_mem_plus_acc_carry, op_add, op_addi, op_mem_plus_acc,
        op_and, op_andi, op_andm, op_call, op_clr,
        op_clrbit, op_wdtclr, op_wdtpre1, op_wdtpre2, op_cpl,
        op_invert_mem_to_acc, op_daa, op_dec, op_mem_minus_one_to_acc, op_halt,
        op_inc, op_mem_plus_one_to_acc, op_jmp, op_nop
    } op_type;

endpackage

// ---- core/alu_add8.sv ----
// eight-bit adder with carry, half carry and signed overflow
`timescale 1ns/100ps
module alu_add8 (
    input  wire logic [7:0] a,     // first operand
    input  wire logic [7:0] b,     // second operand
    input  wire logic       cin,   // carry in
    output logic      [7:0] sum,   // result
    output logic            cout,  // carry out of bit 7
    output logic            half,  // carry out of bit 3
    output logic            ovf    // signed overflow
);
    logic [8:0] full;
    logic [4:0] low;

    // sums and flags
    assign full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    assign low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    assign sum  = full[7:0];
    assign cout = full[8];
    assign half = low[4];
    assign ovf  = (a[7] == b[7]) && (full[7] != a[7]);
endmodule // alu_add8

// ---- core/alu_exec_core.sv ----
// instruction execution datapath with axi4-lite register access
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
module alu_exec_core
    import alu_exec_pkg::*;
#(
    parameter logic [7:0] wdt_prescale_max = WDT_PRESCALE_DEF
) (
    input  wire logic              aclk,     // system clock
    input  wire logic              aresetn,  // sync reset, low
    input  wire logic [ADDR_W-1:0] awaddr,   // write address
    input  wire logic [2:0]        awprot,   // unused protection
    input  wire logic              awvalid,  // write address valid
    output logic                   awready,  // write address ready
    input  wire logic [31:0]       wdata,    // write data
    input  wire logic [3:0]        wstrb,    // byte enables
    input  wire logic              wvalid,   // write data valid
    output logic                   wready,   // write data ready
    output logic [1:0]             bresp,    // write response
    output logic                   bvalid,   // write response valid
    input  wire logic              bready,   // write response ready
    input  wire logic [ADDR_W-1:0] araddr,   // read address
    input  wire logic [2:0]        arprot,   // unused protection
    input  wire logic              arvalid,  // read address valid
    output logic                   arready,  // read address ready
    output logic [31:0]            rdata,    // read data
    output logic [1:0]             rresp,    // read response
    output logic                   rvalid,   // read data valid
    input  wire logic              rready,   // read data ready
    output logic                   sleeping  // core in power-down
);

    // architectural state
    logic [DATA_W-1:0] acc;
    logic [PC_W-1:0]   pc;
    logic              c_flag;
    logic              half_carry_flag;
    logic              z_flag;
    logic              sign_wrap_flag;
    logic              sleep_entry_flag;
    logic              watchdog_expiry_flag;
    logic              pre1_seen;
    logic              pre2_seen;
    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic [PC_W-1:0]   stack [STACK_DEPTH];
    logic [SP_W-1:0]   sp;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0]        watchdog_counter;
    logic [7:0]        prescaler;

    // bus side state
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;

    // register read view for any offset, bit 32 marks a hit
    function automatic logic [32:0] reg_read(input logic [ADDR_W-1:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        if (a == OFS_INSTR) begin
            r[31:0] = 32'h0000_0000;
        end else if (a == OFS_ACC) begin
            r[DATA_W-1:0] = acc;
        end else if (a == OFS_STATUS) begin
            r[ST_C]     = c_flag;
            r[ST_AC]    = half_carry_flag;
            r[ST_Z]     = z_flag;
            r[ST_OV]    = sign_wrap_flag;
            r[ST_PDF]   = sleep_entry_flag;
            r[ST_TO]    = watchdog_expiry_flag;
            r[ST_SLEEP] = sleeping;
            r[ST_PRE1]  = pre1_seen;
            r[ST_PRE2]  = pre2_seen;
        end else if (a == OFS_PC) begin
            r[PC_W-1:0] = pc;
        end else if (a == OFS_MEM_ADDR) begin
            r[ADDR_W-1:0] = mem_addr;
        end else if (a == OFS_MEM_DATA) begin
            r[DATA_W-1:0] = (mem_addr < MEM_DEPTH) ? mem[mem_addr] : 8'h00;
        end else if (a == OFS_WDT) begin
            r[7:0] = watchdog_counter;
        end else if (a == OFS_STACK) begin
            r[SP_W-1:0] = sp;
        end else begin
            r[32] = 1'b0;
        end
        return r;
    endfunction

    // write path: address and data may arrive in either order
    logic        do_write;
    logic [31:0] wmask;
    logic [31:0] merged;
    logic [32:0] old_view;
    logic [32:0] rd_view;

    assign awready  = ~aw_got;
    assign wready   = ~w_got;
    assign arready  = ~rvalid;
    assign do_write = aw_got & w_got & ~bvalid;
    assign wmask    = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                       {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign merged   = (old_view[31:0] & ~wmask) | (w_data_q & wmask);

    // register views; processes so state read inside the function is tracked
    always_comb old_view = reg_read(aw_addr_q);
    always_comb rd_view  = reg_read(araddr);

    logic sw_acc;
    logic sw_status;
    logic sw_pc;
    logic sw_maddr;
    logic sw_mdata;
    logic sw_wake;
    logic exec_go;

    // software write strobes
    assign sw_acc    = do_write && aw_addr_q == OFS_ACC;
    assign sw_status = do_write && aw_addr_q == OFS_STATUS;
    assign sw_pc     = do_write && aw_addr_q == OFS_PC;
    assign sw_maddr  = do_write && aw_addr_q == OFS_MEM_ADDR;
    assign sw_mdata  = do_write && aw_addr_q == OFS_MEM_DATA && mem_addr < MEM_DEPTH;
    assign sw_wake   = do_write && aw_addr_q == OFS_WDT;
    assign exec_go   = do_write && aw_addr_q == OFS_INSTR && !sleeping;

    // instruction fields
    op_type            op;
    logic [2:0]        bit_sel;
    logic [ADDR_W-1:0] ins_addr;
    logic [7:0]        imm;
    logic [PC_W-1:0]   target;
    logic [DATA_W-1:0] mval;

    assign op       = op_type'(merged[INS_OP_LSB +: INS_OP_W]);
    assign bit_sel  = merged[INS_BIT_LSB +: 3];
    assign ins_addr = merged[INS_ADDR_LSB +: ADDR_W];
    assign imm      = merged[INS_IMM_LSB +: 8];
    assign target   = merged[INS_IMM_LSB +: PC_W];
    assign mval     = (ins_addr < MEM_DEPTH) ? mem[ins_addr] : 8'h00;

    // shared adder for all add forms
    logic       add_cin;
    logic [7:0] add_b;
    logic [7:0] add_sum;
    logic       add_c;
    logic       add_h;
    logic       add_v;

    assign add_cin = (op == op_adc || op == op_mem_plus_acc_carry) ? c_flag : 1'b0;
    assign add_b   = (op == op_addi) ? imm : mval;

    alu_add8 u_add (
        .a    (acc),
        .b    (add_b),
        .cin  (add_cin),
        .sum  (add_sum),
        .cout (add_c),
        .half (add_h),
        .ovf  (add_v)
    );

    // decimal adjust of the accumulator
    logic       lo_adj;
    logic [4:0] lo_sum;
    logic [4:0] hi_sum;
    logic       hi_adj;
    logic [3:0] hi_res;

    assign lo_adj = (acc[3:0] > BCD_LIMIT) || half_carry_flag;
    assign lo_sum = {1'b0, acc[3:0]} + (lo_adj ? {1'b0, BCD_STEP} : 5'h00);
    assign hi_sum = {1'b0, acc[7:4]} + {4'h0, lo_sum[4]};
    assign hi_adj = (hi_sum > {1'b0, BCD_LIMIT}) || c_flag;
    assign hi_res = hi_sum[3:0] + (hi_adj ? BCD_STEP : 4'h0);

    // execution results
    logic [DATA_W-1:0] x_val;
    logic              x_to_acc;
    logic              x_to_mem;
    logic              x_arith;
    logic              x_zero;
    logic              x_carry;
    logic [PC_W-1:0]   x_pc;
    logic              x_push;
    logic              x_wdt_clr;
    logic              x_halt;
    logic              x_pre1;
    logic              x_pre2;

    always_comb begin
        x_val     = 8'h00;
        x_to_acc  = 1'b0;
        x_to_mem  = 1'b0;
        x_arith   = 1'b0;
        x_zero    = 1'b0;
        x_carry   = 1'b0;
        x_pc      = pc + 12'h001;
        x_push    = 1'b0;
        x_wdt_clr = 1'b0;
        x_halt    = 1'b0;
        x_pre1    = pre1_seen;
        x_pre2    = pre2_seen;
        case (op)
            op_adc, op_add, op_addi: begin
                x_val    = add_sum;
                x_to_acc = 1'b1;
                x_arith  = 1'b1;
            end
            op_mem_plus_acc_carry, op_mem_plus_acc: begin
                x_val    = add_sum;
                x_to_mem = 1'b1;
                x_arith  = 1'b1;
            end
            op_and: begin
                x_val    = acc & mval;
                x_to_acc = 1'b1;
                x_zero   = 1'b1;
            end
            op_andi: begin
                x_val    = acc & imm;
                x_to_acc = 1'b1;
                x_zero   = 1'b1;
            end
            op_andm: begin
                x_val    = acc & mval;
                x_to_mem = 1'b1;
                x_zero   = 1'b1;
            end
            op_call: begin
                x_push = 1'b1;
                x_pc   = target;
            end
            op_clr: begin
                x_val    = 8'h00;
                x_to_mem = 1'b1;
            end
            op_clrbit: begin
                x_val          = mval;
                x_val[bit_sel] = 1'b0;
                x_to_mem       = 1'b1;
            end
            op_wdtclr: begin
                x_wdt_clr = 1'b1;
            end
            op_wdtpre1: begin
                x_pre1 = 1'b1;
            end
            op_wdtpre2: begin
                x_pre2 = 1'b1;
            end
            op_cpl: begin
                x_val    = ~mval;
                x_to_mem = 1'b1;
                x_zero   = 1'b1;
            end
            op_invert_mem_to_acc: begin
                x_val    = ~mval;
                x_to_acc = 1'b1;
                x_zero   = 1'b1;
            end
            op_daa: begin
                x_val    = {hi_res, lo_sum[3:0]};
                x_to_mem = 1'b1;
                x_carry  = 1'b1;
            end
            op_dec: begin
                x_val    = mval - 8'h01;
                x_to_mem = 1'b1;
                x_zero   = 1'b1;
            end
            op_mem_minus_one_to_acc: begin
                x_val    = mval - 8'h01;
                x_to_acc = 1'b1;
                x_zero   = 1'b1;
            end
            op_halt: begin
                x_halt = 1'b1;
            end
            op_inc: begin
                x_val    = mval + 8'h01;
                x_to_mem = 1'b1;
                x_zero   = 1'b1;
            end
            op_mem_plus_one_to_acc: begin
                x_val    = mval + 8'h01;
                x_to_acc = 1'b1;
                x_zero   = 1'b1;
            end
            op_jmp: begin
                x_pc = target;
            end
            default: begin
                x_val = 8'h00;
            end
        endcase
        // both preclears seen act as a full clear
        if (x_pre1 && x_pre2) begin
            x_wdt_clr = 1'b1;
            x_pre1    = 1'b0;
            x_pre2    = 1'b0;
        end
    end

    // watchdog tick and expiry
    logic presc_wrap;
    logic wdt_expire;

    assign presc_wrap = prescaler == wdt_prescale_max;
    assign wdt_expire = presc_wrap && watchdog_counter == 8'hFF;

    // bus write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_got    <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_got    <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write) begin
                aw_got <= 1'b0;
                w_got  <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= old_view[32] ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // bus read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_view[31:0];
            rresp  <= rd_view[32] ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // accumulator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc <= RST_ACC;
        end else if (sw_acc) begin
            acc <= merged[DATA_W-1:0];
        end else if (exec_go && x_to_acc) begin
            acc <= x_val;
        end
    end

    // data memory, no reset so contents survive power-down
    always_ff @(posedge aclk) begin
        if (sw_mdata) begin
            mem[mem_addr] <= merged[DATA_W-1:0];
        end else if (exec_go && x_to_mem && ins_addr < MEM_DEPTH) begin
            mem[ins_addr] <= x_val;
        end
    end

    // arithmetic and zero flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            c_flag          <= 1'b0;
            half_carry_flag <= 1'b0;
            z_flag          <= 1'b0;
            sign_wrap_flag  <= 1'b0;
        end else if (sw_status) begin
            c_flag          <= merged[ST_C];
            half_carry_flag <= merged[ST_AC];
            z_flag          <= merged[ST_Z];
            sign_wrap_flag  <= merged[ST_OV];
        end else if (exec_go) begin
            if (x_arith) begin
                c_flag          <= add_c;
                half_carry_flag <= add_h;
                sign_wrap_flag  <= add_v;
            end
            if (x_arith || x_zero) begin
                z_flag <= x_val == 8'h00;
            end
            if (x_carry && hi_adj) begin
                c_flag <= 1'b1;
            end
        end
    end

    // program counter and call stack
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc <= RST_PC;
            sp <= '0;
        end else if (sw_pc) begin
            pc <= merged[PC_W-1:0];
        end else if (exec_go) begin
            pc <= x_pc;
            if (x_push) begin
                stack[sp] <= pc + 12'h001;
                sp        <= sp + 3'h1;
            end
        end
    end

    // memory window pointer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_addr <= 8'h00;
        end else if (sw_maddr) begin
            mem_addr <= merged[ADDR_W-1:0];
        end
    end

    // watchdog counter and prescaler
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescaler        <= RST_WDT;
            watchdog_counter <= RST_WDT;
        end else if (exec_go && (x_wdt_clr || x_halt)) begin
            prescaler        <= RST_WDT;
            watchdog_counter <= RST_WDT;
        end else begin
            prescaler <= presc_wrap ? RST_WDT : prescaler + 8'h01;
            if (presc_wrap) begin
                watchdog_counter <= watchdog_counter + 8'h01;
            end
        end
    end

    // expiry, sleep entry and preclear marks; expiry set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_expiry_flag <= 1'b0;
            sleep_entry_flag     <= 1'b0;
            pre1_seen            <= 1'b0;
            pre2_seen            <= 1'b0;
        end else begin
            if (exec_go) begin
                pre1_seen <= x_pre1;
                pre2_seen <= x_pre2;
                if (x_wdt_clr) begin
                    sleep_entry_flag <= 1'b0;
                end else if (x_halt) begin
                    sleep_entry_flag <= 1'b1;
                end
            end
            if (wdt_expire) begin
                watchdog_expiry_flag <= 1'b1;
            end else if (exec_go && (x_wdt_clr || x_halt)) begin
                watchdog_expiry_flag <= 1'b0;
            end
        end
    end

    // power-down state, left by a wake write or watchdog expiry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleeping <= 1'b0;
        end else if (exec_go && x_halt) begin
            sleeping <= 1'b1;
        end else if (sw_wake || wdt_expire) begin
            sleeping <= 1'b0;
        end
    end

endmodule // alu_exec_core

// ---- testbench/alu_exec_chk.sv ----
// bus handshake and power-down checks at the execution core ports
`timescale 1ns/100ps
module alu_exec_chk import alu_exec_pkg::*; (
    input wire logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, // bus controls
    input wire logic arvalid, arready, rvalid, rready, sleeping,              // read, power
    input wire logic [ADDR_W-1:0] awaddr, araddr,                             // addresses
    input wire logic [31:0]       wdata, rdata,                               // data
    input wire logic [1:0]        bresp, rresp                                // responses
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write channels taken on one edge by this bench
    wire wr_go = awvalid && awready && wvalid && wready;
    wire rd_go = arvalid && arready;
    wire instr = wr_go && awaddr == OFS_INSTR;
    // response two edges after the handshake: latch, then execute
    a_write_answer: assert property (wr_go |-> ##2 bvalid) else $error("no bvalid");
    a_write_block: assert property (wr_go |=> !awready && !wready) else $error("ready early");
    a_read_answer: assert property (rd_go |=> rvalid) else $error("no rvalid");
    a_read_block: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("read not released");
    a_wr_unmapped: assert property (wr_go && awaddr > OFS_STACK |-> ##2 bresp == RESP_SLVERR)
        else $error("bad bresp");
    a_rd_unmapped: assert property (rd_go && araddr > OFS_STACK
        |=> rresp == RESP_SLVERR && rdata == 32'h0) else $error("bad rresp");
    a_halt_sleeps: assert property (instr && wdata[4:0] == op_halt |-> ##2 sleeping)
        else $error("no sleep");
    a_wake_write: assert property (sleeping && wr_go && awaddr == OFS_WDT
        |-> ##2 !sleeping) else $error("no wake");
    c_halt: cover property (instr && wdata[4:0] == op_halt);
    c_wake: cover property (sleeping && wr_go);
    c_unmapped: cover property (rd_go && araddr > OFS_STACK);
endmodule // alu_exec_chk

// ---- testbench/bus_sw.sv ----
// register bus master standing in for software on the far side
`timescale 1ns/100ps
module bus_sw import alu_exec_pkg::*; (
    input wire logic aclk, awready, wready, bvalid, arready, rvalid, // answers
    input wire logic [31:0]  rdata,                                 // read data
    output logic             awvalid, wvalid, arvalid,              // requests
    output logic             bready, rready,                        // response ready
    output logic [ADDR_W-1:0] awaddr, araddr,                       // addresses
    output logic [31:0]      wdata                                  // write data
);
    initial {awvalid, wvalid, arvalid, bready, rready, awaddr, araddr, wdata} = '0;
    // offer both write channels, drop each once taken, wait for bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
    endtask
    // read; rready is held high so data is taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
    endtask
endmodule // bus_sw

// ---- testbench/tb_mcu_alu_instruction_exec.sv ----
// self-checking bench for the instruction execution core
`timescale 1ns/100ps
module tb_mcu_alu_instruction_exec import alu_exec_pkg::*; ;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid, sleeping;
    logic bready, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [1:0]        bresp, rresp;
    int num_errors = 0, comparisons = 0;
    localparam logic [7:0] acc = OFS_ACC, mem = OFS_MEM_DATA, pcr = OFS_PC;
    alu_exec_core #(.wdt_prescale_max(8'h03)) alu_exec_core_i (.*, .awprot(3'h0),
        .arprot(3'h0), .wstrb(4'hF));
    bus_sw bus_sw_i (.*);
    always #2 aclk = ~aclk;
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        bus_sw_i.rd(a, d);
        cmp(d & m, e);
    endtask
    // run one op on data byte 5 (bit 7), then check a register and the flags
    task automatic ex(input op_type op, input logic [11:0] t, input logic [7:0] r,
        input logic [11:0] e, input logic [3:0] f);
        bus_sw_i.wr(OFS_INSTR, {4'h0, t, 8'h05, 3'h7, op});
        chk(r, 32'hFFF, {20'h0, e});
        chk(OFS_STATUS, 32'hF, {28'h0, f});
    endtask
    task automatic t_arith;
        bus_sw_i.wr(OFS_MEM_ADDR, 32'h5);
        bus_sw_i.wr(mem, 32'h1);
        bus_sw_i.wr(acc, 32'h7F);
        bus_sw_i.wr(OFS_STATUS, 32'h0);
        ex(op_adc, 12'h0, acc, 12'h80, 4'hA);
        ex(op_mem_plus_acc, 12'h0, mem, 12'h81, 4'h0);
        ex(op_addi, 12'h7F, acc, 12'hFF, 4'h0);
        bus_sw_i.wr(OFS_STATUS, 32'h1);
        ex(op_mem_plus_acc_carry, 12'h0, mem, 12'h81, 4'h3);
        ex(op_add, 12'h0, acc, 12'h80, 4'h3);
        ex(op_andi, 12'h0, acc, 12'h0, 4'h7);
        ex(op_invert_mem_to_acc, 12'h0, acc, 12'h7E, 4'h3);
        ex(op_inc, 12'h0, mem, 12'h82, 4'h3);
        ex(op_mem_minus_one_to_acc, 12'h0, acc, 12'h81, 4'h3);
        ex(op_clrbit, 12'h0, mem, 12'h02, 4'h3);
        ex(op_dec, 12'h0, mem, 12'h01, 4'h3);
        ex(op_andm, 12'h0, mem, 12'h01, 4'h3);
        ex(op_cpl, 12'h0, mem, 12'hFE, 4'h3);
        ex(op_and, 12'h0, acc, 12'h80, 4'h3);
        ex(op_mem_plus_one_to_acc, 12'h0, acc, 12'hFF, 4'h3);
        ex(op_clr, 12'h0, mem, 12'h00, 4'h3);
    endtask
    task automatic t_daa;
        bus_sw_i.wr(acc, 32'h45);
        bus_sw_i.wr(OFS_STATUS, 32'h0);
        ex(op_daa, 12'h0, mem, 12'h45, 4'h0);
        bus_sw_i.wr(acc, 32'h9A);
        ex(op_daa, 12'h0, mem, 12'h00, 4'h1);
        chk(acc, 32'hFF, 32'h9A);
    endtask
    task automatic t_flow;
        bus_sw_i.wr(pcr, 32'h10);
        ex(op_call, 12'h234, pcr, 12'h234, 4'h1);
        chk(OFS_STACK, 32'h7, 32'h1);
        ex(op_jmp, 12'h456, pcr, 12'h456, 4'h1);
        ex(op_nop, 12'h0, pcr, 12'h457, 4'h1);
    endtask
    task automatic t_power;
        ex(op_halt, 12'h0, pcr, 12'h458, 4'h1);
        chk(OFS_STATUS, 32'h1B0, 32'h010);
        cmp({31'h0, sleeping}, 32'h1);
        ex(op_inc, 12'h0, mem, 12'h00, 4'h1);
        bus_sw_i.wr(OFS_WDT, 32'h0);
        ex(op_wdtpre1, 12'h0, pcr, 12'h459, 4'h1);
        chk(OFS_STATUS, 32'h1B0, 32'h090);
        ex(op_wdtpre2, 12'h0, pcr, 12'h45A, 4'h1);
        chk(OFS_STATUS, 32'h1B0, 32'h000);
        ex(op_halt, 12'h0, pcr, 12'h45B, 4'h1);
        bus_sw_i.wr(OFS_WDT, 32'h0);
        ex(op_wdtclr, 12'h0, pcr, 12'h45C, 4'h1);
        chk(OFS_STATUS, 32'h1B0, 32'h000);
        bus_sw_i.wr(8'h44, 32'h5);
        chk(8'h40, 32'hFFFFFFFF, 32'h0);
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // reset, then the scenarios in order
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_arith;
        t_daa;
        t_flow;
        t_power;
        tally_and_finish;
    end
    // hang guard, more than ten times the expected run
    initial begin
        #20000;
        num_errors++;
        tally_and_finish;
    end
endmodule // tb_mcu_alu_instruction_exec
bind alu_exec_core alu_exec_chk alu_exec_chk_i (.*);
